// ---- ber_pci_agent.sv ----
// Behavioural model of the PCI agents that drive the error pins
`timescale 1ns/100ps
`default_nettype none
module ber_pci_agent (
    input wire logic pclk,
    output logic perr_n,
    output logic serr_n
);
    // Both pins are pulled up, so a released line reads high
    initial
    begin
        perr_n = 1'b1;
        serr_n = 1'b1;
    end
    // Length n lets a scenario pick a brief or a held assertion
    task automatic pull(input bit s, input int n);
        @(posedge pclk);
        if (s)
            serr_n <= 1'b0;
        else
            perr_n <= 1'b0;
        repeat (n) @(posedge pclk);
        serr_n <= 1'b1;
        perr_n <= 1'b1;
    endtask : pull
endmodule : ber_pci_agent
`default_nettype wire

// ---- ber_pkg.sv ----
// Types shared by the error reporting block and its neighbours
`default_nettype none
package ber_pkg;
    typedef enum logic [1:0] {
        BER_MA_READ = 2'h0,
        BER_MA_NPWR = 2'h1,
        BER_MA_PWR = 2'h2,
        BER_MA_SPEC = 2'h3
    } ber_ma_kind_e;
    typedef struct packed {
        logic dn_pw_par;
        logic up_pw_par;
        logic up_io_par;
        logic dn_wr_act;
        logic dn_wr_fwd;
        logic ma;
        logic ma_up;
        logic ma_excl;
        ber_ma_kind_e ma_kind;
        logic tgt_abort;
        logic dt_timeout;
    } ber_evt_s;
    typedef struct packed {
        logic fwd_par_pci;
        logic fwd_par_hub;
        logic io_no_dt;
        logic ma_all_ones;
        logic ma_trdy;
        logic ma_drop;
        logic ma_tabort_pri;
        logic ma_tabort_sec;
    } ber_rsp_s;
endpackage : ber_pkg
`default_nettype wire

// ---- ber_regs.svh ----
// Register map, field positions, reset values and timing counts
`ifndef BER_REGS_SVH
`define BER_REGS_SVH
`define BER_OFF_CMD 8'h00
`define BER_OFF_PSTS 8'h04
`define BER_OFF_BCTL 8'h08
`define BER_OFF_SSTS 8'h0c
`define BER_OFF_ECMD 8'h10
`define BER_CMD_PER 6
`define BER_CMD_SERR_EN 8
`define BER_BCTL_SPER 0
`define BER_BCTL_SERR_FWD 1
`define BER_BCTL_MA_MODE 5
`define BER_ECMD_SERR_TA 2
`define BER_ECMD_SERR_TO 3
`define BER_STS_MDPD 8
`define BER_STS_STA 11
`define BER_STS_RMA 13
`define BER_STS_SSE 14
`define BER_STS_DPE 15
`define BER_CMD_WMASK 16'h0140
`define BER_BCTL_WMASK 16'h0023
`define BER_ECMD_WMASK 16'h000c
`define BER_CTRL_RST 16'h0000
`define BER_STS_RST 16'h0000
`define BER_PERR_DLY 2
`endif

// ---- ber_top.sv ----
// Bridge error detection, status recording and system error signalling
`timescale 1ns/100ps
`default_nettype none
`include "ber_regs.svh"
module ber_top (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire ber_pkg::ber_evt_s evt,
    input wire logic perr_in_n,
    input wire logic serr_in_n,
    output logic perr_out_n,
    output logic perr_oe,
    output logic trdy_out_n,
    output logic trdy_oe,
    output logic serr_cyc_req,
    output ber_pkg::ber_rsp_s rsp
);
    function automatic logic ber_hit(input logic [7:0] a,
                                     input logic [7:0] off);
        ber_hit = (a[7:2] == off[7:2]);
    endfunction : ber_hit

    logic [15:0] cmd_reg, cmd_next;
    logic [15:0] bctl_reg, bctl_next;
    logic [15:0] ecmd_reg, ecmd_next;
    logic [15:0] psts_reg, psts_next;
    logic [15:0] ssts_reg, ssts_next;
    logic [31:0] prdata_reg, prdata_next;
    logic serr_cyc_reg, serr_cyc_next;
    ber_pkg::ber_rsp_s rsp_reg, rsp_next;
    logic [`BER_PERR_DLY-1:0] perr_pipe_reg, perr_pipe_next;
    logic [`BER_PERR_DLY-1:0] trdy_pipe_reg, trdy_pipe_next;
    logic [1:0] sync1_reg, sync2_reg;
    logic serr_seen_reg;
    logic [15:0] psts_set, ssts_set, psts_clr, ssts_clr;
    logic wr_en, rd_setup, mapped, serr_any;
    logic per, serr_en, sper, serr_fwd, ma_mode;
    logic tperr, serr_edge, ma_np;

    // Two pins enter from the PCI bus and are synchronised alike
    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++)
        begin : g_sync
            always_ff @(posedge pclk or negedge presetn)
            begin
                if (!presetn)
                begin
                    sync1_reg[gi] <= 1'b1;
                    sync2_reg[gi] <= 1'b1;
                end
                else
                begin
                    sync1_reg[gi] <= (gi == 0) ? perr_in_n : serr_in_n;
                    sync2_reg[gi] <= sync1_reg[gi];
                end
            end
        end
    endgenerate

    assign per = cmd_reg[`BER_CMD_PER];
    assign serr_en = cmd_reg[`BER_CMD_SERR_EN];
    assign sper = bctl_reg[`BER_BCTL_SPER];
    assign serr_fwd = bctl_reg[`BER_BCTL_SERR_FWD];
    assign ma_mode = bctl_reg[`BER_BCTL_MA_MODE];
    // Pin is only meaningful while we master a downstream write
    assign tperr = ~sync2_reg[0] & evt.dn_wr_act;
    // A held SERR assertion yields one special cycle, not one per clock
    assign serr_edge = ~sync2_reg[1] & ~serr_seen_reg;
    assign ma_np = (evt.ma_kind == ber_pkg::BER_MA_READ) |
                   (evt.ma_kind == ber_pkg::BER_MA_NPWR);

    assign mapped = ber_hit(paddr, `BER_OFF_CMD) |
                    ber_hit(paddr, `BER_OFF_PSTS) |
                    ber_hit(paddr, `BER_OFF_BCTL) |
                    ber_hit(paddr, `BER_OFF_SSTS) |
                    ber_hit(paddr, `BER_OFF_ECMD);
    assign wr_en = psel & penable & pwrite & mapped;
    assign rd_setup = psel & ~penable & ~pwrite;
    assign pready = 1'b1;
    assign pslverr = psel & penable & ~mapped;
    assign prdata = prdata_reg;
    assign serr_cyc_req = serr_cyc_reg;
    assign rsp = rsp_reg;
    assign perr_out_n = ~perr_pipe_reg[`BER_PERR_DLY-1];
    assign perr_oe = perr_pipe_reg[`BER_PERR_DLY-1];
    assign trdy_out_n = ~trdy_pipe_reg[`BER_PERR_DLY-1];
    assign trdy_oe = trdy_pipe_reg[`BER_PERR_DLY-1];

    always_comb
    begin
        psts_set = `BER_STS_RST;
        ssts_set = `BER_STS_RST;
        rsp_next = '0;
        serr_any = 1'b0;
        // Event that went through the pipeline decides PERR timing
        perr_pipe_next = {perr_pipe_reg[`BER_PERR_DLY-2:0], 1'b0};
        trdy_pipe_next = {trdy_pipe_reg[`BER_PERR_DLY-2:0], 1'b0};
        if (evt.dn_pw_par)
        begin
            psts_set[`BER_STS_DPE] = 1'b1;
            rsp_next.fwd_par_pci = 1'b1;
            if (per)
                serr_any = 1'b1;
        end
        if (evt.up_pw_par)
        begin
            ssts_set[`BER_STS_DPE] = 1'b1;
            rsp_next.fwd_par_hub = 1'b1;
            if (sper)
                perr_pipe_next[0] = 1'b1;
        end
        if (evt.up_io_par)
        begin
            ssts_set[`BER_STS_DPE] = 1'b1;
            if (sper)
            begin
                rsp_next.io_no_dt = 1'b1;
                perr_pipe_next[0] = 1'b1;
                trdy_pipe_next[0] = 1'b1;
            end
        end
        if (tperr)
        begin
            if (sper)
                ssts_set[`BER_STS_MDPD] = 1'b1;
            if (serr_en & sper & per & ~evt.dn_wr_fwd)
                serr_any = 1'b1;
        end
        if (evt.ma && evt.ma_kind != ber_pkg::BER_MA_SPEC)
        begin
            if (evt.ma_up)
                psts_set[`BER_STS_RMA] = 1'b1;
            else
                ssts_set[`BER_STS_RMA] = 1'b1;
            if (evt.ma_excl & ~evt.ma_up & ma_np)
            begin
                rsp_next.ma_tabort_pri = 1'b1;
                psts_set[`BER_STS_STA] = 1'b1;
            end
            else if (ma_mode & ma_np)
            begin
                if (evt.ma_up)
                begin
                    rsp_next.ma_tabort_sec = 1'b1;
                    ssts_set[`BER_STS_STA] = 1'b1;
                end
                else
                begin
                    rsp_next.ma_tabort_pri = 1'b1;
                    psts_set[`BER_STS_STA] = 1'b1;
                end
            end
            else if (ma_mode)
                serr_any = serr_any | serr_en;
            else if (evt.ma_kind == ber_pkg::BER_MA_READ)
            begin
                rsp_next.ma_all_ones = 1'b1;
                rsp_next.ma_trdy = 1'b1;
            end
            else if (evt.ma_kind == ber_pkg::BER_MA_NPWR)
            begin
                rsp_next.ma_trdy = 1'b1;
                rsp_next.ma_drop = 1'b1;
            end
        end
        if (serr_edge)
        begin
            ssts_set[`BER_STS_SSE] = 1'b1;
            if (serr_fwd & serr_en)
                serr_any = 1'b1;
        end
        if (evt.tgt_abort & serr_en & ecmd_reg[`BER_ECMD_SERR_TA])
            serr_any = 1'b1;
        if (evt.dt_timeout & serr_en & ecmd_reg[`BER_ECMD_SERR_TO])
            serr_any = 1'b1;
        if (serr_any & serr_en)
            psts_set[`BER_STS_SSE] = 1'b1;
        serr_cyc_next = serr_any;
    end

    always_comb
    begin
        cmd_next = cmd_reg;
        bctl_next = bctl_reg;
        ecmd_next = ecmd_reg;
        psts_clr = 16'h0000;
        ssts_clr = 16'h0000;
        prdata_next = prdata_reg;
        if (wr_en)
        begin
            if (ber_hit(paddr, `BER_OFF_CMD))
                cmd_next = pwdata[15:0] & `BER_CMD_WMASK;
            if (ber_hit(paddr, `BER_OFF_BCTL))
                bctl_next = pwdata[15:0] & `BER_BCTL_WMASK;
            if (ber_hit(paddr, `BER_OFF_ECMD))
                ecmd_next = pwdata[15:0] & `BER_ECMD_WMASK;
            if (ber_hit(paddr, `BER_OFF_PSTS))
                psts_clr = pwdata[15:0];
            if (ber_hit(paddr, `BER_OFF_SSTS))
                ssts_clr = pwdata[15:0];
        end
        // Set beats clear so an event in the clearing cycle survives
        psts_next = (psts_reg & ~psts_clr) | psts_set;
        ssts_next = (ssts_reg & ~ssts_clr) | ssts_set;
        // Read data is latched in setup so the access phase needs no wait
        if (rd_setup)
        begin
            prdata_next = 32'h0000_0000;
            if (ber_hit(paddr, `BER_OFF_CMD))
                prdata_next[15:0] = cmd_reg;
            if (ber_hit(paddr, `BER_OFF_PSTS))
                prdata_next[15:0] = psts_reg;
            if (ber_hit(paddr, `BER_OFF_BCTL))
                prdata_next[15:0] = bctl_reg;
            if (ber_hit(paddr, `BER_OFF_SSTS))
                prdata_next[15:0] = ssts_reg;
            if (ber_hit(paddr, `BER_OFF_ECMD))
                prdata_next[15:0] = ecmd_reg;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cmd_reg <= `BER_CTRL_RST;
            bctl_reg <= `BER_CTRL_RST;
            ecmd_reg <= `BER_CTRL_RST;
            psts_reg <= `BER_STS_RST;
            ssts_reg <= `BER_STS_RST;
            prdata_reg <= 32'h0000_0000;
            serr_cyc_reg <= 1'b0;
            rsp_reg <= '0;
            perr_pipe_reg <= '0;
            trdy_pipe_reg <= '0;
            serr_seen_reg <= 1'b0;
        end
        else
        begin
            cmd_reg <= cmd_next;
            bctl_reg <= bctl_next;
            ecmd_reg <= ecmd_next;
            psts_reg <= psts_next;
            ssts_reg <= ssts_next;
            prdata_reg <= prdata_next;
            serr_cyc_reg <= serr_cyc_next;
            rsp_reg <= rsp_next;
            perr_pipe_reg <= perr_pipe_next;
            trdy_pipe_reg <= trdy_pipe_next;
            serr_seen_reg <= ~sync2_reg[1];
        end
    end

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    AST_DNPW_STATUS: assert property (
        evt.dn_pw_par |=> psts_reg[`BER_STS_DPE] && rsp.fwd_par_pci
            && (serr_cyc_req == $past(per)))
        else $error("downstream posted parity not handled");
    AST_PERR_TWO: assert property (
        evt.up_pw_par && sper |-> ##2 perr_oe && !perr_out_n)
        else $error("PERR not driven two cycles after data");
    AST_PERR_QUIET: assert property (
        !sper && !evt.up_pw_par && !evt.up_io_par ##1 !sper
            |-> ##1 !perr_oe)
        else $error("PERR driven without cause");
    AST_UPPW_FWD: assert property (
        evt.up_pw_par |=> ssts_reg[`BER_STS_DPE] && rsp.fwd_par_hub)
        else $error("upstream posted parity not forwarded");
    AST_TPERR_MDPD: assert property (
        tperr && sper |=> ssts_reg[`BER_STS_MDPD])
        else $error("target PERR not recorded");
    AST_IO_TRDY: assert property (
        evt.up_io_par && sper |=> rsp.io_no_dt ##1 trdy_oe && !trdy_out_n)
        else $error("I/O parity case not ended correctly");
    AST_IO_NOFWD: assert property (
        evt.up_io_par && !evt.up_pw_par |=> !rsp.fwd_par_hub)
        else $error("I/O parity error forwarded");
    AST_MA_SPEC: assert property (
        evt.ma && evt.ma_kind == ber_pkg::BER_MA_SPEC && !evt.tgt_abort
            |=> !rsp.ma_tabort_pri && !rsp.ma_tabort_sec)
        else $error("special cycle abort reported");
    AST_MA0_READ: assert property (
        evt.ma && !ma_mode && !evt.ma_excl
            && evt.ma_kind == ber_pkg::BER_MA_READ
            |=> rsp.ma_all_ones && rsp.ma_trdy)
        else $error("mode 0 read abort did not return ones");
    AST_MA1_UP: assert property (
        evt.ma && ma_mode && evt.ma_up && ma_np
            |=> rsp.ma_tabort_sec && ssts_reg[`BER_STS_STA]
            && psts_reg[`BER_STS_RMA])
        else $error("mode 1 upstream abort not target aborted");
    AST_EXCL: assert property (
        evt.ma && evt.ma_excl && !evt.ma_up && ma_np
            |=> rsp.ma_tabort_pri && psts_reg[`BER_STS_STA])
        else $error("exclusive abort not target aborted");
    AST_SERR_PIN: assert property (
        $fell(sync2_reg[1]) && serr_fwd && serr_en
            |=> serr_cyc_req && ssts_reg[`BER_STS_SSE])
        else $error("PCI SERR not forwarded");
    AST_STICKY: assert property (
        psts_reg[`BER_STS_DPE]
            && !(wr_en && ber_hit(paddr, `BER_OFF_PSTS)
            && pwdata[`BER_STS_DPE]) |=> psts_reg[`BER_STS_DPE])
        else $error("status bit lost without clear");
    AST_TPERR_SERR: assert property (
        tperr && serr_en && sper && per && !evt.dn_wr_fwd
            |=> serr_cyc_req && psts_reg[`BER_STS_SSE])
        else $error("target PERR did not raise a system error");
    AST_MA0_NPWR: assert property (
        evt.ma && !ma_mode && !evt.ma_excl
            && evt.ma_kind == ber_pkg::BER_MA_NPWR
            |=> rsp.ma_trdy && rsp.ma_drop && !rsp.ma_tabort_pri)
        else $error("mode 0 write abort not completed");
    AST_MA_RMA_DN: assert property (
        evt.ma && !evt.ma_up && evt.ma_kind != ber_pkg::BER_MA_SPEC
            |=> ssts_reg[`BER_STS_RMA])
        else $error("downstream abort not recorded");
    AST_MA1_POSTED: assert property (
        evt.ma && ma_mode && serr_en && evt.ma_kind == ber_pkg::BER_MA_PWR
            |=> serr_cyc_req && psts_reg[`BER_STS_SSE])
        else $error("mode 1 posted abort did not raise a system error");
    // Other error sources are masked so only the abort path is judged
    AST_MA_SPEC_QUIET: assert property (
        evt.ma && evt.ma_kind == ber_pkg::BER_MA_SPEC && !evt.dn_pw_par
            && !evt.tgt_abort && !evt.dt_timeout && !tperr && !serr_edge
            |=> !serr_cyc_req)
        else $error("special cycle abort raised a system error");
    AST_TA_SERR: assert property (
        evt.tgt_abort && serr_en && ecmd_reg[`BER_ECMD_SERR_TA]
            |=> serr_cyc_req)
        else $error("target abort not reported");
    AST_TO_SERR: assert property (
        evt.dt_timeout && serr_en && ecmd_reg[`BER_ECMD_SERR_TO]
            |=> serr_cyc_req)
        else $error("delayed transaction timeout not reported");
    COV_PERR: cover property (evt.up_pw_par && sper ##2 perr_oe);
    COV_MA1_POSTED: cover property (evt.ma && ma_mode
        && evt.ma_kind == ber_pkg::BER_MA_PWR ##1 serr_cyc_req);
    COV_TA_SERR: cover property (evt.tgt_abort ##1 serr_cyc_req);
    COV_CLR: cover property (wr_en && ber_hit(paddr, `BER_OFF_SSTS)
        && ssts_reg != 16'h0000);
endmodule : ber_top
`default_nettype wire

// ---- testbench.sv ----
// Self-checking bench for the bridge error reporting block
`timescale 1ns/100ps
`default_nettype none
`include "ber_regs.svh"
module testbench;
    localparam logic [15:0] dpe = 16'h0001 << `BER_STS_DPE;
    localparam logic [15:0] sse = 16'h0001 << `BER_STS_SSE;
    localparam logic [15:0] rma = 16'h0001 << `BER_STS_RMA;
    localparam logic [15:0] sta = 16'h0001 << `BER_STS_STA;
    localparam logic [15:0] mdpd = 16'h0001 << `BER_STS_MDPD;
    localparam logic [15:0] per = 16'h0001 << `BER_CMD_PER;
    localparam logic [15:0] sen = 16'h0001 << `BER_CMD_SERR_EN;
    localparam logic [15:0] sper = 16'h0001 << `BER_BCTL_SPER;
    localparam logic [15:0] fwd = 16'h0001 << `BER_BCTL_SERR_FWD;
    localparam logic [15:0] mam = 16'h0001 << `BER_BCTL_MA_MODE;
    localparam logic [15:0] eta = 16'h0001 << `BER_ECMD_SERR_TA;
    localparam logic [15:0] eto = 16'h0001 << `BER_ECMD_SERR_TO;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready, pslverr, perr_out_n, perr_oe, trdy_out_n, trdy_oe;
    logic serr_cyc_req, perr_in_n, serr_in_n;
    ber_pkg::ber_rsp_s rsp;
    ber_pkg::ber_evt_s evt = '0;
    int errors = 0;
    int tests_run = 0;
    logic [32:0] rd_q[$];
    logic [12:0] ev_q[$];
    wire logic [12:0] ov = {serr_cyc_req, rsp, perr_oe, ~perr_out_n,
        trdy_oe, ~trdy_out_n};
    always #5 pclk = ~pclk;
    ber_top i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .evt(evt),
        .perr_in_n(perr_in_n), .serr_in_n(serr_in_n),
        .perr_out_n(perr_out_n), .perr_oe(perr_oe), .trdy_out_n(trdy_out_n),
        .trdy_oe(trdy_oe), .serr_cyc_req(serr_cyc_req), .rsp(rsp));
    ber_pci_agent i_pci (.pclk(pclk), .perr_n(perr_in_n),
        .serr_n(serr_in_n));
    task automatic cmp_rd(input logic [32:0] e, input logic [32:0] g);
        tests_run++;
        if (g !== e)
        begin
            errors++;
            $display("unexpected read at %0t: got %h expected %h", $time, g, e);
        end
    endtask : cmp_rd
    task automatic cmp_ev(input logic [12:0] e, input logic [12:0] g);
        tests_run++;
        if (g !== e)
        begin
            errors++;
            $display("unexpected pins at %0t: got %h expected %h", $time, g, e);
        end
    endtask : cmp_ev
    // Any nonzero response pops the oldest note, so extra pulses fail
    always @(posedge pclk)
    begin
        if (psel && penable && pready && !pwrite)
            cmp_rd(rd_q.size() ? rd_q.pop_front() : 33'bx, {pslverr, prdata});
        if (presetn && ov !== 13'h0000)
            cmp_ev(ev_q.size() ? ev_q.pop_front() : 13'bx, ov);
    end
    task automatic apb(input bit w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        // No wait-state limit here: only the watchdog ends a stuck wait
        while (pready !== 1'b1)
            @(posedge pclk);
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb
    task automatic rd(input logic [7:0] a, input logic [15:0] e);
        rd_q.push_back({17'h0, e});
        apb(1'b0, a, 32'h0);
    endtask : rd
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        apb(1'b1, a, {16'h0, d});
    endtask : wr
    task automatic stat(input logic [15:0] p, input logic [15:0] s);
        rd(`BER_OFF_PSTS, p);
        rd(`BER_OFF_SSTS, s);
        wr(`BER_OFF_PSTS, p);
        wr(`BER_OFF_SSTS, s);
        rd(`BER_OFF_PSTS, 16'h0);
        rd(`BER_OFF_SSTS, 16'h0);
    endtask : stat
    task automatic cfg(input logic [15:0] c, input logic [15:0] b,
        input logic [15:0] e);
        wr(`BER_OFF_CMD, c);
        wr(`BER_OFF_BCTL, b);
        wr(`BER_OFF_ECMD, e);
    endtask : cfg
    task automatic ev(input logic [11:0] v);
        evt <= ber_pkg::ber_evt_s'(v);
        @(posedge pclk);
        evt <= '0;
        repeat (6) @(posedge pclk);
    endtask : ev
    function automatic logic [12:0] ov_e(input logic s, input logic [7:0] r,
        input logic p, input logic t);
        return {s, r, p, p, t, t};
    endfunction : ov_e
    task automatic close_out;
        $display("comparisons %0d mismatches %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : close_out
    initial
    begin
        #200000;
        errors++;
        close_out();
    end
    initial
    begin
        logic [31:0] r;
        logic [7:0] rv;
        logic [15:0] p, q;
        logic [7:0] offs[3];
        logic [15:0] msk[3];
        logic s;
        offs = '{`BER_OFF_CMD, `BER_OFF_BCTL, `BER_OFF_ECMD};
        msk = '{`BER_CMD_WMASK, `BER_BCTL_WMASK, `BER_ECMD_WMASK};
        r = $urandom(32'h640f7dcc);
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        for (int a = 0; a < 5; a++)
            rd(8'(a * 4), 16'h0);
        rd_q.push_back({1'b1, 32'h0});
        apb(1'b0, 8'h14, 32'h0);
        for (int i = 0; i < 3; i++)
        begin
            r = $urandom;
            wr(offs[i], r[15:0]);
            rd(offs[i], r[15:0] & msk[i]);
        end
        $display("test registers done");
        cfg(16'h0, 16'h0, 16'h0);
        ev_q.push_back(ov_e(1'b0, 8'h80, 1'b0, 1'b0));
        ev(12'h800);
        stat(dpe, 16'h0);
        cfg(per | sen, 16'h0, 16'h0);
        ev_q.push_back(ov_e(1'b1, 8'h80, 1'b0, 1'b0));
        ev(12'h800);
        wr(`BER_OFF_PSTS, dpe);
        stat(sse, 16'h0);
        $display("test hub parity done");
        // Secondary response on, then off: no PERR or TRDY drive then
        for (int e = 1; e >= 0; e--)
        begin
            cfg(16'h0, e ? sper : 16'h0, 16'h0);
            ev_q.push_back(ov_e(1'b0, 8'h40, 1'b0, 1'b0));
            if (e)
                ev_q.push_back(ov_e(1'b0, 8'h00, 1'b1, 1'b0));
            ev(12'h400);
            stat(16'h0, dpe);
            if (e)
            begin
                ev_q.push_back(ov_e(1'b0, 8'h20, 1'b0, 1'b0));
                ev_q.push_back(ov_e(1'b0, 8'h00, 1'b1, 1'b1));
            end
            ev(12'h200);
            stat(16'h0, dpe);
        end
        $display("test pci parity done");
        // Last pass turns secondary response off: nothing may be recorded
        for (int f = 0; f < 3; f++)
        begin
            cfg(per | sen, f == 2 ? 16'h0 : sper, 16'h0);
            evt <= ber_pkg::ber_evt_s'(f == 1 ? 12'h180 : 12'h100);
            if (f == 0)
                ev_q.push_back(ov_e(1'b1, 8'h00, 1'b0, 1'b0));
            i_pci.pull(1'b0, 1);
            repeat (6) @(posedge pclk);
            evt <= '0;
            @(posedge pclk);
            stat(f == 0 ? sse : 16'h0, f == 2 ? 16'h0 : mdpd);
        end
        cfg(per | sen, sper, 16'h0);
        i_pci.pull(1'b0, 1);
        repeat (6) @(posedge pclk);
        stat(16'h0, 16'h0);
        $display("test target parity done");
        cfg(sen, fwd, 16'h0);
        ev_q.push_back(ov_e(1'b1, 8'h00, 1'b0, 1'b0));
        i_pci.pull(1'b1, 4);
        repeat (6) @(posedge pclk);
        stat(sse, sse);
        cfg(sen, 16'h0, eta | eto);
        ev_q.push_back(ov_e(1'b1, 8'h00, 1'b0, 1'b0));
        ev(12'h002);
        ev_q.push_back(ov_e(1'b1, 8'h00, 1'b0, 1'b0));
        ev(12'h001);
        stat(sse, 16'h0);
        // Either the source enable or the primary enable is missing
        for (int g = 0; g < 2; g++)
        begin
            cfg(g ? 16'h0 : sen, g ? fwd : 16'h0, g ? (eta | eto) : 16'h0);
            i_pci.pull(1'b1, 1);
            repeat (6) @(posedge pclk);
            ev(12'h002);
            ev(12'h001);
            stat(16'h0, sse);
        end
        $display("test system error done");
        for (int m = 0; m < 2; m++)
            for (int u = 0; u < 2; u++)
                for (int k = 0; k < 4; k++)
                begin
                    cfg(sen, m ? mam : 16'h0, 16'h0);
                    s = (m == 1 && k == 2);
                    rv = (m == 0 && k == 0) ? 8'h18 : 8'h00;
                    rv |= (m == 0 && k == 1) ? 8'h0c : 8'h00;
                    rv |= (m == 1 && k < 2) ? (u ? 8'h01 : 8'h02) : 8'h00;
                    p = (k < 3 && u) ? rma : 16'h0;
                    q = (k < 3 && !u) ? rma : 16'h0;
                    p |= (m == 1 && k < 2 && !u) ? sta : 16'h0;
                    q |= (m == 1 && k < 2 && u) ? sta : 16'h0;
                    p |= s ? sse : 16'h0;
                    if (s || rv != 8'h00)
                        ev_q.push_back(ov_e(s, rv, 1'b0, 1'b0));
                    ev(12'(32'h40 + u * 32 + k * 4));
                    stat(p, q);
                end
        for (int m = 0; m < 4; m++)
        begin
            cfg(sen, m[1] ? mam : 16'h0, 16'h0);
            ev_q.push_back(ov_e(1'b0, 8'h02, 1'b0, 1'b0));
            ev(12'(32'h50 + m[0] * 4));
            stat(sta, rma);
        end
        $display("test master abort done");
        cmp_ev(13'h0000, 13'(ev_q.size()));
        close_out();
    end
endmodule : testbench
`default_nettype wire
